//--- rtl/cwsl_pkg.sv
//==============================================================================
// constants of the configuration word shadow loader
//==============================================================================
package cwsl_pkg;

   //===========================================================================
   // widths and counts
   //===========================================================================
   localparam int          ADDR_W      = 24;
   localparam int          WORD_W      = 24;
   localparam int          SEQ_W       = 12;
   localparam int          NUM_WORDS   = 6;
   localparam logic [3:0]  SETTLE_CNT  = 4'h3;   // strap settle cycles after release
   localparam logic [2:0]  IDX_SEQ_A   = 3'h0;
   localparam logic [2:0]  IDX_SEQ_B   = 3'h1;
   localparam logic [2:0]  IDX_WORD0   = 3'h2;
   localparam logic [2:0]  IDX_LAST    = 3'h7;

   //===========================================================================
   // flash and register addresses
   //===========================================================================
   localparam logic [23:0] PANEL_B_OFS = 24'h400000;  // second panel base offset
   localparam logic [23:0] SEQ_ADDR    = 24'h00affc;  // boot_sequence_word
   localparam logic [23:0] CFG_LO      = 24'h00af80;  // start of configuration space
   localparam logic [23:0] CFG_HI      = 24'h00afff;  // end of configuration space
   localparam logic [23:0] STATUS_ADDR = 24'h00aff0;
   localparam logic [23:0] CTRL_ADDR   = 24'h00afe0;
   localparam logic [NUM_WORDS-1:0][23:0] WORD_ADDR = {
      24'h00afa0,    // watchdog_config_word
      24'h00af9c,    // oscillator_config_word
      24'h00af98,    // oscillator_select_word
      24'h00af94,    // signature_reserved_word
      24'h00af90,    // boot_segment_limit_word
      24'h00af80     // security_config_word
   };

   //===========================================================================
   // field positions and values
   //===========================================================================
   localparam int          SEQ_LSB     = 0;           // sequence number in bits 11:0
   localparam int          ST_DONE_B   = 0;
   localparam int          ST_PANEL_B  = 1;
   localparam int          ST_DUAL_B   = 2;
   localparam int          ST_BLANK_B  = 3;
   localparam int          ST_SWAP_B   = 4;
   localparam int          CT_SWAP_B   = 0;
   localparam logic [23:0] ERASED_WORD = 24'hffffff;

   typedef enum logic [1:0] {
      CWSL_SETTLE  = 2'b00,
      CWSL_ISSUE   = 2'b01,
      CWSL_CAPTURE = 2'b10,
      CWSL_DONE    = 2'b11
   } cwsl_state_e;

endpackage : cwsl_pkg

//--- rtl/cwsl_loader.sv
module cwsl_loader (
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire logic                dual_mode_pin,
   output logic [23:0]              flash_addr,
   output logic                     flash_rd,
   input  wire logic [23:0]         flash_rdata,
   input  wire logic                fetch_valid,
   input  wire logic [23:0]         fetch_addr,
   output logic                     reset_req,
   input  wire logic [23:0]         reg_addr,
   input  wire logic [15:0]         reg_wdata,
   input  wire logic                reg_wr,
   input  wire logic                reg_rd,
   output logic [23:0]              reg_rdata,
   output logic                     load_done,
   output logic                     active_panel,
   output logic [23:0]              security_config_word,
   output logic [23:0]              boot_segment_limit_word,
   output logic [23:0]              signature_reserved_word,
   output logic [23:0]              oscillator_select_word,
   output logic [23:0]              oscillator_config_word,
   output logic [23:0]              watchdog_config_word
);

   //===========================================================================
   // state record
   //===========================================================================
   typedef struct packed {
      logic [2:0]                          sync;
      cwsl_pkg::cwsl_state_e               state;
      logic [3:0]                          settle;
      logic [2:0]                          idx;
      logic [11:0]                         seq_a;
      logic                                panel;
      logic                                dual;
      logic [cwsl_pkg::NUM_WORDS-1:0][23:0] shadow;
      logic                                done;
      logic                                blank;
      logic                                swapped;
      logic                                rst_req;
      logic [23:0]                         faddr;
      logic                                frd;
      logic [23:0]                         rdata;
   } cwsl_state_s;

   cwsl_state_s state_reg;
   cwsl_state_s state_next;

   logic [23:0] panel_base;
   logic [23:0] word_addr;
   logic [23:0] ofs_a;
   logic [23:0] ofs_b;
   logic        cfg_fetch;
   logic [11:0] seq_b;

   //===========================================================================
   // address helpers
   //===========================================================================
   // base of the panel whose words are being read
   assign panel_base = state_reg.panel ? cwsl_pkg::PANEL_B_OFS : 24'h000000;
   // flash word for the current index: two sequence slots, then six words
   always_comb begin
      if (state_reg.idx == cwsl_pkg::IDX_SEQ_A) begin
         word_addr = cwsl_pkg::SEQ_ADDR;
      end else if (state_reg.idx == cwsl_pkg::IDX_SEQ_B) begin
         word_addr = cwsl_pkg::SEQ_ADDR | cwsl_pkg::PANEL_B_OFS;
      end else begin
         word_addr = cwsl_pkg::WORD_ADDR[state_reg.idx - cwsl_pkg::IDX_WORD0] | panel_base;
      end
   end

   // fetch address folded into either panel
   assign ofs_a = fetch_addr;
   assign ofs_b = fetch_addr & ~cwsl_pkg::PANEL_B_OFS;
   assign cfg_fetch = fetch_valid
                   && (((ofs_a >= cwsl_pkg::CFG_LO) && (ofs_a <= cwsl_pkg::CFG_HI))
                    || ((ofs_b >= cwsl_pkg::CFG_LO) && (ofs_b <= cwsl_pkg::CFG_HI)));

   assign seq_b = flash_rdata[cwsl_pkg::SEQ_LSB +: cwsl_pkg::SEQ_W];

   //===========================================================================
   // next state
   //===========================================================================
   // strap sync, load sequencer, swap control, fetch guard and read port
   always_comb begin
      state_next      = state_reg;
      state_next.sync = {state_reg.sync[1:0], dual_mode_pin};
      state_next.frd  = 1'b0;

      case (state_reg.state)
         cwsl_pkg::CWSL_SETTLE: begin
            // settle counter runs out first, then the strap is taken once the second and third stages agree
            if (state_reg.settle != cwsl_pkg::SETTLE_CNT) begin
               state_next.settle = state_reg.settle + 4'h1;
            end else if (state_reg.sync[2] == state_reg.sync[1]) begin
               state_next.dual  = state_reg.sync[2];
               state_next.idx   = state_reg.sync[2] ? cwsl_pkg::IDX_SEQ_A : cwsl_pkg::IDX_WORD0;
               state_next.state = cwsl_pkg::CWSL_ISSUE;
            end
         end
         cwsl_pkg::CWSL_ISSUE: begin
            // fetch from the top of program flash
            state_next.faddr = word_addr;
            state_next.frd   = 1'b1;
            state_next.state = cwsl_pkg::CWSL_CAPTURE;
         end
         cwsl_pkg::CWSL_CAPTURE: begin
            // read data is valid now, in the same cycle as the strobe
            if (state_reg.idx == cwsl_pkg::IDX_SEQ_A) begin
               state_next.seq_a = flash_rdata[cwsl_pkg::SEQ_LSB +: cwsl_pkg::SEQ_W];
            end else if (state_reg.idx == cwsl_pkg::IDX_SEQ_B) begin
               // lower sequence number wins, a tie keeps panel a
               state_next.panel = seq_b < state_reg.seq_a;
            end else begin
               // copy word into shadow; from active panel
               state_next.shadow[state_reg.idx - cwsl_pkg::IDX_WORD0] = flash_rdata;
               // an erased page shows up as all-ones words
               if (flash_rdata == cwsl_pkg::ERASED_WORD) begin
                  state_next.blank = 1'b1;
               end
            end
            if (state_reg.idx == cwsl_pkg::IDX_LAST) begin
               state_next.done  = 1'b1;
               state_next.state = cwsl_pkg::CWSL_DONE;
            end else begin
               state_next.idx   = state_reg.idx + 3'h1;
               state_next.state = cwsl_pkg::CWSL_ISSUE;
            end
         end
         cwsl_pkg::CWSL_DONE: begin
            // soft swap flips the panel only, shadows stay
            if (reg_wr && (reg_addr == cwsl_pkg::CTRL_ADDR)
                && reg_wdata[cwsl_pkg::CT_SWAP_B] && state_reg.dual) begin
               state_next.panel   = ~state_reg.panel;
               state_next.swapped = 1'b1;
            end
         end
         default: begin
            state_next.state = cwsl_pkg::CWSL_SETTLE;
         end
      endcase

      // request stays up until the reset arrives
      if (cfg_fetch) begin
         state_next.rst_req = 1'b1;
      end

      // register read port, data one cycle after the strobe
      state_next.rdata = 24'h000000;
      if (reg_rd) begin
         for (int i = 0; i < cwsl_pkg::NUM_WORDS; i++) begin
            if (reg_addr == cwsl_pkg::WORD_ADDR[i]) begin
               state_next.rdata = state_reg.shadow[i];
            end
         end
         if (reg_addr == cwsl_pkg::STATUS_ADDR) begin
            state_next.rdata[cwsl_pkg::ST_DONE_B]  = state_reg.done;
            state_next.rdata[cwsl_pkg::ST_PANEL_B] = state_reg.panel;
            state_next.rdata[cwsl_pkg::ST_DUAL_B]  = state_reg.dual;
            state_next.rdata[cwsl_pkg::ST_BLANK_B] = state_reg.blank;
            state_next.rdata[cwsl_pkg::ST_SWAP_B]  = state_reg.swapped;
         end
      end
   end

   //===========================================================================
   // state register
   //===========================================================================
   // volatile shadows cleared by reset; any reset reloads
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   //===========================================================================
   // outputs
   //===========================================================================
   // shadows leave only through flops written during a load
   assign flash_addr              = state_reg.faddr;
   assign flash_rd                = state_reg.frd;
   assign reset_req               = state_reg.rst_req;
   assign reg_rdata               = state_reg.rdata;
   assign load_done               = state_reg.done;
   assign active_panel            = state_reg.panel;
   assign security_config_word    = state_reg.shadow[0];
   assign boot_segment_limit_word = state_reg.shadow[1];
   assign signature_reserved_word = state_reg.shadow[2];
   assign oscillator_select_word  = state_reg.shadow[3];
   assign oscillator_config_word  = state_reg.shadow[4];
   assign watchdog_config_word    = state_reg.shadow[5];

   //===========================================================================
   // checks
   //===========================================================================
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   chk_load_start: assert property (
      $fell(sys_rst) |-> !load_done)
      else $error("load_done set right after reset");

   chk_load_bound: assert property (
      $rose(state_reg.state == cwsl_pkg::CWSL_ISSUE) && (state_reg.idx == 3'h0)
      |-> ##[15:17] load_done)
      else $error("dual load did not finish in time");

   chk_read_pair: assert property (
      flash_rd |-> ##1 !flash_rd)
      else $error("flash read strobe longer than one cycle");

   chk_shadow_hold: assert property (
      load_done |=> $stable(state_reg.shadow))
      else $error("shadow changed after load");

   chk_swap_keep: assert property (
      $changed(active_panel) && $past(load_done) |-> $stable(watchdog_config_word))
      else $error("soft swap altered a shadow");

   chk_panel_pick: assert property (
      (state_reg.state == cwsl_pkg::CWSL_CAPTURE) && (state_reg.idx == cwsl_pkg::IDX_SEQ_B)
      |=> active_panel == ($past(seq_b) < $past(state_reg.seq_a)))
      else $error("wrong active partition");

   chk_cfg_reset: assert property (
      cfg_fetch |=> reset_req [*2])
      else $error("config fetch gave no reset request");

   chk_copy_word: assert property (
      (state_reg.state == cwsl_pkg::CWSL_CAPTURE) && (state_reg.idx == cwsl_pkg::IDX_LAST)
      |=> watchdog_config_word == $past(flash_rdata))
      else $error("last word not copied");

   chk_panel_addr: assert property (
      flash_rd && (state_reg.idx >= cwsl_pkg::IDX_WORD0)
      |-> flash_addr[22] == active_panel)
      else $error("word read from wrong panel");

   cov_dual_b: cover property (load_done && active_panel && !state_reg.swapped);
   cov_single: cover property ($rose(load_done) && !state_reg.dual);
   cov_swap:   cover property ($rose(state_reg.swapped));
   cov_cfgrst: cover property ($rose(reset_req));

endmodule : cwsl_loader

//--- bench/cwsl_flash_model.sv
// ==========================================
// flash array holding the configuration words
// ==========================================
module cwsl_flash_model (
   input  wire logic        clk_sys,
   input  wire logic [23:0] flash_addr,
   input  wire logic        flash_rd,
   output logic      [23:0] flash_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] mem [logic [23:0]];
   logic [23:0] word;
   // words from the top, blank reads ones
   // the array answers within the strobe cycle, so the loader takes it at the next edge
   always @(*) begin
      word = mem.exists(flash_addr) ? mem[flash_addr] : cwsl_pkg::ERASED_WORD;
      flash_rdata = flash_rd ? word : ~word; // data invalid outside the answer cycle
   end
endmodule : cwsl_flash_model

//--- bench/cwsl_tb.sv
module cwsl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   // ==========================================
   logic        clk_sys, sys_rst, dual_mode_pin, flash_rd, fetch_valid;
   logic        reg_wr, reg_rd, reset_req, load_done, active_panel, rd_d;
   logic [23:0] flash_addr, flash_rdata, fetch_addr, reg_addr, reg_rdata;
   logic [15:0] reg_wdata;
   logic [23:0] shd [6];
   logic [23:0] img [2][6];
   logic [23:0] exp_q [$];
   logic [23:0] fa [4] = '{24'h00af7f, 24'h00b000, 24'h00af80, 24'h40afff};
   int          error_cnt, samples_checked;
   // ==========================================
   // design and flash
   // ==========================================
   cwsl_loader dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .dual_mode_pin(dual_mode_pin),
      .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .reset_req(reset_req),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .load_done(load_done), .active_panel(active_panel),
      .security_config_word(shd[0]), .boot_segment_limit_word(shd[1]),
      .signature_reserved_word(shd[2]), .oscillator_select_word(shd[3]),
      .oscillator_config_word(shd[4]), .watchdog_config_word(shd[5]));
   cwsl_flash_model flash_u (.clk_sys(clk_sys), .flash_addr(flash_addr),
      .flash_rd(flash_rd), .flash_rdata(flash_rdata));
   // ==========================================
   // tasks
   // ==========================================
   task automatic end_sim;
      if (error_cnt == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim
   task automatic check(input string nm, input logic [23:0] ex, input logic [23:0] got);
      samples_checked++;
      if (got !== ex) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask : check
   task automatic reg_read(input logic [23:0] a, input logic [23:0] e);
      reg_rd   <= 1'b1;
      reg_wr   <= 1'b0;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clk_sys);
   endtask : reg_read
   task automatic reg_write(input logic [23:0] a, input logic [15:0] d);
      reg_wr    <= 1'b1;
      reg_rd    <= 1'b0;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
   endtask : reg_write
   task automatic idle;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge clk_sys);
   endtask : idle
   // image at the top, spare bits as ones
   task automatic load_panel(input int p, input logic [11:0] seq);
      logic [23:0] base;
      base = (p != 0) ? cwsl_pkg::PANEL_B_OFS : 24'h000000;
      flash_u.mem[cwsl_pkg::SEQ_ADDR | base] = {12'hfff, seq};
      for (int i = 0; i < 6; i++) begin
         img[p][i] = 24'hff0000 | 24'($urandom);
         flash_u.mem[cwsl_pkg::WORD_ADDR[i] | base] = img[p][i];
      end
   endtask : load_panel
   task automatic do_reset;
      sys_rst <= 1'b1;
      repeat (16) @(posedge clk_sys);
      for (int i = 0; i < 6; i++) check("shadow in reset", 24'h0, shd[i]);
      check("reset_req in reset", 24'h0, {23'h0, reset_req});
      sys_rst <= 1'b0;
      for (int n = 0; n < 60 && load_done !== 1'b1; n++) @(posedge clk_sys);
      check("load_done", 24'h1, {23'h0, load_done});
   endtask : do_reset
   task automatic check_shadows(input int p);
      for (int i = 0; i < 6; i++) reg_read(cwsl_pkg::WORD_ADDR[i], img[p][i]);
      idle();
      @(negedge clk_sys);
      for (int i = 0; i < 6; i++) check("shadow", img[p][i], shd[i]);
      @(posedge clk_sys);
   endtask : check_shadows
   task automatic check_all(input int p, input logic [23:0] st);
      reg_read(cwsl_pkg::STATUS_ADDR, st);
      check_shadows(p);
      check("active_panel", 24'(p), {23'h0, active_panel});
   endtask : check_all
   // ==========================================
   // clock, read monitor, watchdog
   // ==========================================
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // compare read data with the oldest note
   always @(posedge clk_sys) begin
      if (rd_d && exp_q.size() > 0)
         check("reg_rdata", exp_q.pop_front(), reg_rdata);
      rd_d <= reg_rd;
   end
   // cut a hang short
   initial begin
      #2000000;
      error_cnt++;
      end_sim();
   end
   // ==========================================
   // main sequence
   // ==========================================
   initial begin
      {sys_rst, dual_mode_pin, fetch_valid, reg_wr, reg_rd} = 5'b10000;
      {fetch_addr, reg_addr, reg_wdata} = '0;
      error_cnt = 0;
      samples_checked = 0;
      void'($urandom(32'h0788));
      load_panel(0, 12'h005);
      load_panel(1, 12'h003);
      @(posedge clk_sys);
      // single mode, then ignored swap and shadow writes
      do_reset();
      check_all(0, 24'h000001);
      reg_write(cwsl_pkg::CTRL_ADDR, 16'h0001);
      reg_write(cwsl_pkg::WORD_ADDR[5], 16'($urandom));
      reg_read(24'h000100, 24'h000000);
      check_all(0, 24'h000001);
      // dual mode, lower sequence number wins
      dual_mode_pin <= 1'b1;
      do_reset();
      check_all(1, 24'h000007);
      reg_write(cwsl_pkg::CTRL_ADDR, 16'h0001);
      idle();
      repeat (8) @(posedge clk_sys);
      check_shadows(1);
      // tie keeps panel a, new contents reloaded
      load_panel(0, 12'h003);
      do_reset();
      check_all(0, 24'h000005);
      // erased last page loads blank words
      dual_mode_pin <= 1'b0;
      flash_u.mem.delete(cwsl_pkg::SEQ_ADDR);
      for (int i = 0; i < 6; i++) begin
         flash_u.mem.delete(cwsl_pkg::WORD_ADDR[i]);
         img[0][i] = cwsl_pkg::ERASED_WORD;
      end
      do_reset();
      check_all(0, 24'h000009);
      // fetch guard around the configuration space
      for (int k = 0; k < 4; k++) begin
         fetch_valid <= 1'b1;
         fetch_addr  <= fa[k];
         @(posedge clk_sys);
         fetch_valid <= 1'b0;
         @(negedge clk_sys);
         check("reset_req", {23'h0, k > 1}, {23'h0, reset_req});
         repeat (4) @(posedge clk_sys);
         check("reset_req held", {23'h0, k > 1}, {23'h0, reset_req});
         if (k > 1)
            do_reset();
      end
      end_sim();
   end
endmodule : cwsl_tb
